// File: refclk_pkg.sv
// Purpose: Shared constants and types for the reference clock distribution block
// Assumes: One 100 MHz system clock; all rates below it are enable pulses
// Notes: Lane numbers are held one-based; zero means no lane mapped
package refclk_pkg;
   localparam int unsigned NUM_OUTPUTS = 9;
   localparam int unsigned LOW_GROUP_SIZE = 6;
   localparam int unsigned LANE_W = 5;
   localparam logic [4:0] LOW_LANE_MIN = 5'h01;
   localparam logic [4:0] LOW_LANE_MAX = 5'h0c;
   localparam logic [4:0] HIGH_LANE_MIN = 5'h0d;
   localparam logic [4:0] HIGH_LANE_MAX = 5'h14;
   localparam logic [4:0] LANE_RESET = 5'h00;
   // Clock rates in kHz
   localparam int unsigned SYS_CLK_KHZ = 100000;
   localparam int unsigned XTAL_KHZ = 38400;
   localparam int unsigned PCIE_REF_KHZ = 100000;
   // Fixed domain enable: phase accumulator step for 38.4 of 100
   localparam logic [16:0] FIXED_STEP = 17'h00180;
   localparam logic [16:0] FIXED_MOD = 17'h003e8;
   // Spread modulation: triangle up to pll_ctrl.ssc_level, one step every SSC_DIV+1 cycles
   localparam logic [7:0] SSC_DIV = 8'h0f;
   localparam logic [7:0] SSC_SPAN = 8'h64;
   localparam logic [7:0] SSC_LEVEL_RESET = 8'h32;
   localparam logic [7:0] BCLK_RATIO_RESET = 8'h01;

   typedef enum logic [1:0] {
      PWR_RESET,
      PWR_AFTER_RESET,
      PWR_ACTIVE,
      PWR_SLEEP
   } power_state_e;

   typedef struct packed {
      logic [7:0] ssc_level;
      logic ssc_enable;
      logic [7:0] bclk_ratio;
      logic emi_dither_enable;
   } pll_ctrl_s;

   typedef struct packed {
      logic fixed_en;
      logic pcie_ref_en;
      logic bclk_en;
      logic [7:0] ssc_phase;
   } clk_status_s;
endpackage

// File: lane_map_ram.sv
// Purpose: Holds the lane assignment of each clock request line
// Assumes: Single write port, single registered read port
// Notes: Contents clear to the unmapped value at reset
`timescale 1ns/100ps
`default_nettype none
module lane_map_ram #(
   parameter int unsigned DEPTH = 9,
   parameter int unsigned WIDTH = 5
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic [3:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [3:0] rd_addr,
   output logic [WIDTH-1:0] rd_data,
   output logic [DEPTH*WIDTH-1:0] all_data
);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [WIDTH-1:0] mem_next [DEPTH];
   logic [WIDTH-1:0] rd_reg;
   logic [WIDTH-1:0] rd_next;

   // Next contents and read word
   always_comb begin
      for (int i = 0; i < DEPTH; i++) begin
         mem_next[i] = (wr_en && wr_addr == 4'(i)) ? wr_data : mem_reg[i];
      end
      rd_next = (32'(rd_addr) < DEPTH) ? mem_reg[rd_addr] : '0;
   end

   // Storage; read data registered
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_reg[i] <= '0;
         end
         rd_reg <= '0;
      end else begin
         mem_reg <= mem_next;
         rd_reg <= rd_next;
      end
   end

   assign rd_data = rd_reg;
   always_comb begin
      for (int i = 0; i < DEPTH; i++) begin
         all_data[i*WIDTH +: WIDTH] = mem_reg[i];
      end
   end
endmodule
`default_nettype wire

// File: pcie_refclk_distribution.sv
// Purpose: Reference clock generation and gating for attached PCIe devices
// Assumes: ref_clk 100 MHz; output pairs carry enable-gated clock levels
// Notes: No software registers; configuration arrives on plain ports
//
// Behaviour
// - Nine 100 MHz differential outputs; spread is carried as phase status, not on the pairs.
// - Request lines 5..0 map to any lane 1-12 via outputs 5..0.
// - Request lines 8..6 map to any lane 13-20 via outputs 8..6.
// - Outputs toggle in and after reset, low in S4/S5; requests never driven.
// - Each request line is open drain; a device pulls it to ask for clock.
// - Fixed timebase comes from a 38.4 MHz crystal, one input, one output.
// - Fixed 38.4 MHz clock has no spread; feeds display, voltage id, counters, Type-C.
// - Internal PCIe reference is 100 MHz with spread; clocks PCIe controllers.
// - A PLL derives the base clock from the fixed crystal clock.
// - Base PLL has emission mitigation and overclock ratio controls.
`timescale 1ns/100ps
`default_nettype none
module pcie_refclk_distribution #(
   parameter int unsigned NUM_OUT = refclk_pkg::NUM_OUTPUTS
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic resume_well_reset_n,
   input wire logic sleep_s4s5,
   input wire logic xtal_in,
   output logic xtal_out,
   input wire logic [NUM_OUT-1:0] refclk_request_n_in,
   output logic [NUM_OUT-1:0] refclk_request_n_out,
   output logic [NUM_OUT-1:0] refclk_request_n_oe_n,
   input wire logic map_wr_en,
   input wire logic [3:0] map_wr_index,
   input wire logic [4:0] map_wr_lane,
   output logic map_wr_reject,
   input wire logic [3:0] map_rd_index,
   output logic [4:0] map_rd_lane,
   input wire refclk_pkg::pll_ctrl_s pll_ctrl,
   output logic [NUM_OUT-1:0] pcie_refclk_out_pos,
   output logic [NUM_OUT-1:0] pcie_refclk_out_neg,
   output logic [NUM_OUT-1:0] lane_clock_active,
   output logic pcie_ref_domain_clock,
   output logic fixed_clk_en,
   output logic bclk_en,
   output refclk_pkg::clk_status_s status
);
   logic rst_sync1_reg, rst_sync2_reg;
   logic rst_n;

   // Reset release through two flops
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync1_reg <= 1'b0;
         rst_sync2_reg <= 1'b0;
      end else begin
         rst_sync1_reg <= 1'b1;
         rst_sync2_reg <= rst_sync1_reg;
      end
   end
   assign rst_n = rst_sync2_reg;

   // Lane range check per request index
   function automatic logic lane_legal(input logic [3:0] idx, input logic [4:0] lane);
      if (32'(idx) < refclk_pkg::LOW_GROUP_SIZE) begin
         lane_legal = lane >= refclk_pkg::LOW_LANE_MIN && lane <= refclk_pkg::LOW_LANE_MAX;
      end else if (32'(idx) < NUM_OUT) begin
         lane_legal = lane >= refclk_pkg::HIGH_LANE_MIN && lane <= refclk_pkg::HIGH_LANE_MAX;
      end else begin
         lane_legal = 1'b0;
      end
   endfunction

   logic [NUM_OUT*5-1:0] map_all;
   logic map_accept;
   // Out-of-group lanes are refused so a low output never serves a high lane
   assign map_accept = map_wr_en && lane_legal(map_wr_index, map_wr_lane);
   assign map_wr_reject = map_wr_en && !map_accept;

   lane_map_ram #(.DEPTH(NUM_OUT), .WIDTH(refclk_pkg::LANE_W)) u_map (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .wr_en(map_accept),
      .wr_addr(map_wr_index),
      .wr_data(map_wr_lane),
      .rd_addr(map_rd_index),
      .rd_data(map_rd_lane),
      .all_data(map_all)
   );

   // Power state tracking relative to the resume-well reset
   refclk_pkg::power_state_e pwr_reg, pwr_next;
   always_comb begin
      pwr_next = pwr_reg;
      case (pwr_reg)
         refclk_pkg::PWR_RESET: if (resume_well_reset_n) pwr_next = refclk_pkg::PWR_AFTER_RESET;
         refclk_pkg::PWR_AFTER_RESET: pwr_next = refclk_pkg::PWR_ACTIVE;
         refclk_pkg::PWR_ACTIVE: if (sleep_s4s5) pwr_next = refclk_pkg::PWR_SLEEP;
         refclk_pkg::PWR_SLEEP: if (!sleep_s4s5) pwr_next = refclk_pkg::PWR_ACTIVE;
         default: pwr_next = refclk_pkg::PWR_RESET;
      endcase
      if (!resume_well_reset_n) pwr_next = refclk_pkg::PWR_RESET;
      else if (sleep_s4s5) pwr_next = refclk_pkg::PWR_SLEEP;
   end

   // Divider phases: fixed 38.4 accumulator, spread triangle, base PLL ratio
   logic [16:0] facc_reg, facc_next;
   logic fen_reg, fen_next;
   logic [7:0] sdiv_reg, sdiv_next, sph_reg, sph_next, bcnt_reg, bcnt_next;
   logic sdir_reg, sdir_next, ben_reg, ben_next, pcie_ph_reg, pcie_ph_next;
   logic xtal_q_reg, xtal_q_next;
   always_comb begin
      // Fixed domain enable, no spread applied
      if (facc_reg + refclk_pkg::FIXED_STEP >= refclk_pkg::FIXED_MOD) begin
         facc_next = facc_reg + refclk_pkg::FIXED_STEP - refclk_pkg::FIXED_MOD;
         fen_next = 1'b1;
      end else begin
         facc_next = facc_reg + refclk_pkg::FIXED_STEP;
         fen_next = 1'b0;
      end
      // Spread phase walks a triangle up to the chosen level
      sdiv_next = (sdiv_reg == refclk_pkg::SSC_DIV) ? 8'h00 : sdiv_reg + 8'h01;
      sph_next = sph_reg;
      sdir_next = sdir_reg;
      if (!pll_ctrl.ssc_enable) begin
         sph_next = 8'h00;
      end else if (sdiv_reg == refclk_pkg::SSC_DIV) begin
         if (sdir_reg) begin
            sph_next = sph_reg + 8'h01;
            if (sph_reg + 8'h01 >= pll_ctrl.ssc_level) sdir_next = 1'b0;
         end else begin
            sph_next = (sph_reg == 8'h00) ? 8'h00 : sph_reg - 8'h01;
            if (sph_reg <= 8'h01) sdir_next = 1'b1;
         end
      end
      // Base clock derived from fixed enables, ratio sets overclock
      ben_next = 1'b0;
      bcnt_next = bcnt_reg;
      if (fen_reg) begin
         bcnt_next = bcnt_reg + 8'h01;
         if (bcnt_reg + 8'h01 >= pll_ctrl.bclk_ratio) begin
            bcnt_next = 8'h00;
            ben_next = 1'b1;
         end
      end
      // Dither drops the base pulse on odd spread phases for emission spread
      if (pll_ctrl.emi_dither_enable && sph_reg[0]) ben_next = 1'b0;
      // PCIe reference toggles each cycle: spread is carried as phase status
      pcie_ph_next = !pcie_ph_reg;
      xtal_q_next = xtal_in;
   end

   // Output gating per pair
   logic [NUM_OUT-1:0] act_reg, act_next;
   logic [NUM_OUT-1:0] pos_reg, pos_next, neg_reg, neg_next;
   always_comb begin
      for (int i = 0; i < NUM_OUT; i++) begin
         // Toggle through reset and just after it; the grant follows the request of a mapped line
         act_next[i] = !refclk_request_n_in[i] && map_all[i*5 +: 5] != refclk_pkg::LANE_RESET;
         if (pwr_reg == refclk_pkg::PWR_SLEEP) begin
            pos_next[i] = 1'b0;
            neg_next[i] = 1'b0;
         end else if (pwr_reg != refclk_pkg::PWR_ACTIVE || act_reg[i]) begin
            pos_next[i] = !pcie_ph_reg;
            neg_next[i] = pcie_ph_reg;
         end else begin
            pos_next[i] = 1'b0;
            neg_next[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pwr_reg <= refclk_pkg::PWR_RESET;
         facc_reg <= '0;
         fen_reg <= 1'b0;
         sdiv_reg <= 8'h00;
         sph_reg <= 8'h00;
         sdir_reg <= 1'b1;
         bcnt_reg <= 8'h00;
         ben_reg <= 1'b0;
         pcie_ph_reg <= 1'b0;
         xtal_q_reg <= 1'b0;
         act_reg <= '0;
         pos_reg <= '0;
         neg_reg <= '0;
      end else begin
         pwr_reg <= pwr_next;
         facc_reg <= facc_next;
         fen_reg <= fen_next;
         sdiv_reg <= sdiv_next;
         sph_reg <= sph_next;
         sdir_reg <= sdir_next;
         bcnt_reg <= bcnt_next;
         ben_reg <= ben_next;
         pcie_ph_reg <= pcie_ph_next;
         xtal_q_reg <= xtal_q_next;
         act_reg <= act_next;
         pos_reg <= pos_next;
         neg_reg <= neg_next;
      end
   end

   // Request lines are only ever sensed, never pulled by this end
   assign refclk_request_n_out = '0;
   assign refclk_request_n_oe_n = '1;
   assign xtal_out = !xtal_q_reg;
   assign pcie_refclk_out_pos = pos_reg;
   assign pcie_refclk_out_neg = neg_reg;
   assign lane_clock_active = act_reg;
   assign pcie_ref_domain_clock = pcie_ph_reg;
   assign fixed_clk_en = fen_reg;
   assign bclk_en = ben_reg;
   assign status = '{fixed_en: fen_reg, pcie_ref_en: pcie_ph_reg, bclk_en: ben_reg,
                     ssc_phase: sph_reg};

   // Checks
   property p_sleep_low;
      @(posedge ref_clk) disable iff (!rst_n)
         pwr_reg == refclk_pkg::PWR_SLEEP |=> (pcie_refclk_out_pos == '0 && pcie_refclk_out_neg == '0);
   endproperty
   a_sleep_low: assert property (p_sleep_low) else $error("Outputs not low in sleep");
   property p_reset_toggle;
      @(posedge ref_clk) disable iff (!rst_n)
         pwr_reg == refclk_pkg::PWR_RESET ##1 pwr_reg == refclk_pkg::PWR_RESET
         |=> pcie_refclk_out_pos[0] != $past(pcie_refclk_out_pos[0]);
   endproperty
   a_reset_toggle: assert property (p_reset_toggle) else $error("No toggle in reset");
   property p_undriven;
      @(posedge ref_clk) disable iff (!rst_n) refclk_request_n_oe_n == '1;
   endproperty
   a_undriven: assert property (p_undriven) else $error("Request line driven");
   property p_map_range;
      @(posedge ref_clk) disable iff (!rst_n)
         map_wr_en && map_wr_index < 4'h6 && map_wr_lane > refclk_pkg::LOW_LANE_MAX |-> map_wr_reject;
   endproperty
   a_map_range: assert property (p_map_range) else $error("Low group took high lane");
   property p_map_high;
      @(posedge ref_clk) disable iff (!rst_n)
         map_wr_en && map_wr_index == 4'h7 && map_wr_lane == 5'h0d |-> !map_wr_reject;
   endproperty
   a_map_high: assert property (p_map_high) else $error("High lane refused");
   property p_grant;
      @(posedge ref_clk) disable iff (!rst_n)
         !refclk_request_n_in[0] && map_all[4:0] != 5'h00 |=> lane_clock_active[0];
   endproperty
   a_grant: assert property (p_grant) else $error("Requested clock not granted");
   // In the active state every granted pair must come out complementary one cycle after its grant
   property p_diff;
      @(posedge ref_clk) disable iff (!rst_n)
         pwr_reg == refclk_pkg::PWR_ACTIVE
         |=> ((pcie_refclk_out_pos ^ pcie_refclk_out_neg) & $past(act_reg)) == $past(act_reg);
   endproperty
   a_diff: assert property (p_diff) else $error("Pair not complementary");
   property p_fixed_rate;
      @(posedge ref_clk) disable iff (!rst_n) fixed_clk_en |=> !fixed_clk_en;
   endproperty
   a_fixed_rate: assert property (p_fixed_rate) else $error("Fixed enable too fast");
   property p_no_ssc;
      @(posedge ref_clk) disable iff (!rst_n) !pll_ctrl.ssc_enable |=> status.ssc_phase == 8'h00;
   endproperty
   a_no_ssc: assert property (p_no_ssc) else $error("Spread active while off");
endmodule
`default_nettype wire

// File: refclk_device_model.sv
// Purpose: Attached devices that ask for reference clocks on open-drain lines
// Assumes: Bench sets want per line; slow mode answers one cycle late
// Notes: Model only pulls low or lets go; the board pull-up gives the high level
`timescale 1ns/100ps
`default_nettype none
module refclk_device_model (
   input wire logic ref_clk,
   input wire logic slow,
   input wire logic [8:0] want,
   output logic [8:0] pull_low
);
   logic [8:0] want_reg;
   // Delayed copy lets the bench test a sluggish device
   always_ff @(posedge ref_clk) begin
      want_reg <= want;
   end
   // Open drain: assert low only, release to pull-up
   assign pull_low = slow ? (want & want_reg) : want;
endmodule
`default_nettype wire

// File: test_pcie_refclk_distribution.sv
// Purpose: Self-checking bench for reference clock distribution
// Assumes: 100 MHz ref_clk; inputs change 1 ns after the rising edge
// Notes: Request wires are resolved here from device pulls and design enables
`timescale 1ns/100ps
`default_nettype none
`define CHECK(act, exp, msg) begin compares++; if ((act) !== (exp)) begin n_errors++; \
   $display("CHECK FAILED t=%0t %s", $time, msg); end end
module test_pcie_refclk_distribution;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic resume_well_reset_n = 1'b0;
   logic sleep_s4s5 = 1'b0;
   logic xtal_in = 1'b0;
   logic xtal_out;
   logic slow = 1'b0;
   logic [8:0] want = 9'h000;
   logic [8:0] dev_pull, req_wire, req_out, req_oe_n, pos, neg, active, prev;
   logic map_wr_en = 1'b0;
   logic [3:0] map_wr_index = 4'h0;
   logic [4:0] map_wr_lane = 5'h00;
   logic map_wr_reject;
   logic [3:0] map_rd_index = 4'h0;
   logic [4:0] map_rd_lane;
   // Firmware side keeps the spread level at its default throughout
   refclk_pkg::pll_ctrl_s pll_ctrl = '{refclk_pkg::SSC_LEVEL_RESET, 1'b1,
      refclk_pkg::BCLK_RATIO_RESET, 1'b0};
   logic pcie_ref_domain_clock, fixed_clk_en, dom_prev;
   logic bclk_en;
   refclk_pkg::clk_status_s status;
   int cnt2;
   int n_errors = 0;
   int compares = 0;
   int cnt;
   always #5 ref_clk = ~ref_clk;
   // Line is low if any party pulls it; otherwise the pull-up wins
   assign req_wire = ~(dev_pull | (~req_oe_n & ~req_out));
   refclk_device_model i_refclk_device_model (.ref_clk(ref_clk), .slow(slow), .want(want),
      .pull_low(dev_pull));
   pcie_refclk_distribution i_pcie_refclk_distribution (.ref_clk(ref_clk), .arst_n(arst_n),
      .resume_well_reset_n(resume_well_reset_n), .sleep_s4s5(sleep_s4s5), .xtal_in(xtal_in),
      .xtal_out(xtal_out), .refclk_request_n_in(req_wire), .refclk_request_n_out(req_out),
      .refclk_request_n_oe_n(req_oe_n), .map_wr_en(map_wr_en), .map_wr_index(map_wr_index),
      .map_wr_lane(map_wr_lane), .map_wr_reject(map_wr_reject), .map_rd_index(map_rd_index),
      .map_rd_lane(map_rd_lane), .pll_ctrl(pll_ctrl), .pcie_refclk_out_pos(pos),
      .pcie_refclk_out_neg(neg), .lane_clock_active(active),
      .pcie_ref_domain_clock(pcie_ref_domain_clock), .fixed_clk_en(fixed_clk_en),
      .bclk_en(bclk_en), .status(status));
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic map_write(input logic [3:0] idx, input logic [4:0] lane, input logic rej);
      map_wr_en = 1'b1;
      map_wr_index = idx;
      map_wr_lane = lane;
      #1;
      `CHECK(map_wr_reject, rej, "write reject flag")
      tick(1);
      map_wr_en = 1'b0;
      // One idle edge so back-to-back calls never re-raise the strobe in one step
      tick(1);
   endtask
   task automatic map_check(input logic [3:0] idx, input logic [4:0] lane);
      map_rd_index = idx;
      tick(1);
      `CHECK(map_rd_lane, lane, "mapped lane readback")
   endtask
   // Pairs must run complementary and flip every cycle
   task automatic check_toggle(input logic [8:0] mask);
      prev = pos;
      tick(1);
      `CHECK(pos & mask, ~prev & mask, "pair not toggling")
      `CHECK(neg & mask, ~pos & mask, "pair not complementary")
   endtask
   task automatic test_reset_states();
      tick(3);
      check_toggle(9'h1ff);
      `CHECK(req_oe_n, 9'h1ff, "request driven in reset")
      resume_well_reset_n = 1'b1;
      check_toggle(9'h1ff);
      tick(4);
      `CHECK(pos | neg, 9'h000, "idle pairs not gated")
      $display("test reset_states done");
   endtask
   task automatic test_mapping();
      map_write(4'h0, 5'h0c, 1'b0);
      map_write(4'h0, 5'h0d, 1'b1);
      map_check(4'h0, 5'h0c);
      map_write(4'h5, 5'h01, 1'b0);
      map_write(4'h6, 5'h0c, 1'b1);
      map_write(4'h6, 5'h14, 1'b0);
      map_write(4'h8, 5'h0d, 1'b0);
      map_write(4'h7, 5'h0d, 1'b0);
      map_write(4'h8, 5'h15, 1'b1);
      map_write(4'h9, 5'h03, 1'b1);
      map_check(4'h6, 5'h14);
      map_check(4'h8, 5'h0d);
      map_check(4'h1, 5'h00);
      $display("test mapping done");
   endtask
   task automatic test_grant();
      want = 9'h141;
      tick(2);
      `CHECK(active, 9'h141, "grant after request")
      tick(1);
      check_toggle(9'h141);
      `CHECK(pos & ~9'h141, 9'h000, "ungranted pair running")
      want = 9'h003;
      tick(4);
      `CHECK(active, 9'h001, "unmapped or released line granted")
      want = 9'h000;
      slow = 1'b1;
      tick(2);
      want = 9'h020;
      tick(3);
      `CHECK(active, 9'h020, "slow device grant")
      $display("test grant done");
   endtask
   task automatic test_sleep();
      sleep_s4s5 = 1'b1;
      tick(2);
      `CHECK({pos, neg}, 18'h00000, "pairs not gated in sleep")
      `CHECK(req_oe_n, 9'h1ff, "request driven in sleep")
      sleep_s4s5 = 1'b0;
      tick(3);
      check_toggle(9'h020);
      $display("test sleep done");
   endtask
   task automatic test_clocks();
      xtal_in = 1'b1;
      tick(1);
      `CHECK(xtal_out, 1'b0, "crystal drive high")
      xtal_in = 1'b0;
      tick(1);
      `CHECK(xtal_out, 1'b1, "crystal drive low")
      cnt = 0;
      cnt2 = 0;
      for (int i = 0; i < 1000; i++) begin
         dom_prev = pcie_ref_domain_clock;
         tick(1);
         if (fixed_clk_en === 1'b1) begin
            cnt++;
         end
         if (bclk_en === 1'b1) begin
            cnt2++;
         end
         if (i == 7) begin
            `CHECK(pcie_ref_domain_clock, ~dom_prev, "pcie domain clock stuck")
         end
      end
      `CHECK(cnt, 384, "fixed enable rate")
      `CHECK(cnt2, 384, "base clock rate at ratio one")
      $display("test clocks done");
   endtask
   // Counts base clock pulses over 1000 cycles, eight full accumulator periods
   task automatic count_bclk();
      cnt = 0;
      for (int i = 0; i < 1000; i++) begin
         tick(1);
         if (bclk_en === 1'b1) begin
            cnt++;
         end
      end
   endtask
   // Spread on and off, base ratio and dither; level stays at default
   task automatic test_pll();
      pll_ctrl.ssc_enable = 1'b0;
      tick(2);
      `CHECK(status.ssc_phase, 8'h00, "spread phase moving while off")
      pll_ctrl.ssc_enable = 1'b1;
      tick(64);
      `CHECK(status.ssc_phase != 8'h00, 1'b1, "spread phase not moving")
      `CHECK(status.ssc_phase <= refclk_pkg::SSC_LEVEL_RESET, 1'b1, "spread past level")
      pll_ctrl.bclk_ratio = 8'h02;
      tick(2);
      count_bclk();
      `CHECK(cnt, 192, "base clock rate at ratio two")
      pll_ctrl.bclk_ratio = refclk_pkg::BCLK_RATIO_RESET;
      pll_ctrl.emi_dither_enable = 1'b1;
      tick(2);
      count_bclk();
      `CHECK(cnt < 384, 1'b1, "dither leaves base clock untouched")
      pll_ctrl.emi_dither_enable = 1'b0;
      tick(2);
      $display("test pll done");
   endtask
   // Second reset in mid-run clears maps and grants
   task automatic test_reset_again();
      arst_n = 1'b0;
      tick(2);
      `CHECK({pos, neg, active}, 27'h0000000, "outputs not cleared in reset")
      `CHECK(req_oe_n, 9'h1ff, "request driven in block reset")
      arst_n = 1'b1;
      tick(4);
      `CHECK(active, 9'h000, "grant survived reset")
      map_check(4'h5, 5'h00);
      $display("test reset_again done");
   endtask
   task automatic give_verdict();
      $display("compares=%0d n_errors=%0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Guard against a hang; the tests need well under 5000 cycles
   initial begin
      #200000;
      n_errors++;
      give_verdict();
   end
   initial begin
      tick(10);
      arst_n = 1'b1;
      test_reset_states();
      test_mapping();
      test_grant();
      test_sleep();
      test_clocks();
      test_pll();
      test_reset_again();
      give_verdict();
   end
endmodule
`default_nettype wire
